/* dtq_top.sv */
// Trigger qualification and break request logic of the debug module.
`timescale 1ns/100ps
module dtq_top (
	// Clock and reset.
	input  wire logic                 clk_in,
	input  wire logic                 reset_in,
	// Register port.
	input  wire dtq_pkg::dtq_req_type req_in,
	output logic [7:0]                rdata_out,
	// Watched CPU bus and opcode execution.
	input  wire dtq_pkg::dtq_bus_type bus_in,
	input  wire logic                 op_exec_in,
	input  wire logic [15:0]          op_addr_in,
	// Trace FIFO logic.
	input  wire logic                 fifo_full_in,
	output logic                      trig_out,
	output logic                      store_out,
	output logic                      begin_trace_out,
	output logic                      high_byte_en_out,
	output logic                      run_clear_out,
	// CPU break and interrupt.
	output logic                      break_out,
	output logic                      break_tag_out,
	output logic                      irq_out
);

	// ==========================================================
	// Registers.
	localparam int IRQ_W_L = dtq_pkg::IRQ_W;
	logic [7:0]                 ctrl;
	logic [7:0]                 trig_sel;
	logic [15:0]                cmp_a;
	logic [15:0]                cmp_b;
	logic                       flag_a;
	logic                       flag_b;
	logic                       seen_a;
	logic                       pend_a;
	logic                       pend_b;
	logic [IRQ_W_L-1:0]         irq_st;
	logic [IRQ_W_L-1:0]         irq_msk;
	dtq_pkg::dtq_state_type     state;
	logic                       seen_trig;

	// ==========================================================
	// Register decode.
	wire wr_ctrl  = req_in.wr && req_in.addr == dtq_pkg::ADDR_CTRL;
	wire wr_trig  = req_in.wr && req_in.addr == dtq_pkg::ADDR_TRIG;
	wire wr_cah   = req_in.wr && req_in.addr == dtq_pkg::ADDR_CMPAH;
	wire wr_cal   = req_in.wr && req_in.addr == dtq_pkg::ADDR_CMPAL;
	wire wr_cbh   = req_in.wr && req_in.addr == dtq_pkg::ADDR_CMPBH;
	wire wr_cbl   = req_in.wr && req_in.addr == dtq_pkg::ADDR_CMPBL;
	wire wr_ist   = req_in.wr && req_in.addr == dtq_pkg::ADDR_IRQST;
	wire wr_imsk  = req_in.wr && req_in.addr == dtq_pkg::ADDR_IRQMSK;
	wire armed    = ctrl[dtq_pkg::CTL_ARM];
	wire enabled  = ctrl[dtq_pkg::CTL_EN];

	// ==========================================================
	// Mode decode.
	wire [3:0] mode     = trig_sel[3:0];
	wire       tag_type = trig_sel[dtq_pkg::TRG_TYPE];
	wire       ev_only  = mode == dtq_pkg::MODE_EV_B
	                   || mode == dtq_pkg::MODE_A_EV_B;
	wire       begin_tr = ev_only || trig_sel[dtq_pkg::TRG_BEGIN];

	// ==========================================================
	// Comparators with direction qualification.
	wire a_hit = bus_in.valid && bus_in.addr == cmp_a;
	wire b_hit = bus_in.valid && bus_in.addr == cmp_b;
	wire a_dir = !ctrl[dtq_pkg::CTL_RWAE]
	          || bus_in.read == ctrl[dtq_pkg::CTL_RWA];
	wire b_dir = !ctrl[dtq_pkg::CTL_RWBE]
	          || bus_in.read == ctrl[dtq_pkg::CTL_RWB];
	wire b_data = bus_in.valid && bus_in.data == cmp_b[7:0];
	wire match_a = a_hit && a_dir;
	wire match_b = b_hit && b_dir;
	wire in_rng  = bus_in.addr >= cmp_a && bus_in.addr <= cmp_b;
	wire rng_dir = a_dir && bus_in.valid;

	// Tag type: matches are held until the opcode at the address runs.
	wire tag_a = op_exec_in && pend_a && op_addr_in == cmp_a;
	wire tag_b = op_exec_in && pend_b && op_addr_in == cmp_b;
	wire ev_a  = tag_type ? tag_a : match_a;
	wire ev_b  = tag_type ? tag_b : match_b;

	// ==========================================================
	// Trigger condition per mode.
	logic cond;
	always_comb begin
		unique case (mode)
			dtq_pkg::MODE_A_ONLY:   cond = ev_a;
			dtq_pkg::MODE_A_OR_B:   cond = ev_a || ev_b;
			dtq_pkg::MODE_A_THEN_B: cond = (seen_a || ev_a) && ev_b;
			dtq_pkg::MODE_EV_B:     cond = ev_b;
			dtq_pkg::MODE_A_EV_B:   cond = (seen_a || ev_a) && ev_b;
			dtq_pkg::MODE_A_AND_B:  cond = ev_a && b_data;
			dtq_pkg::MODE_A_NOT_B:  cond = ev_a && !b_data;
			dtq_pkg::MODE_INSIDE:   cond = rng_dir && in_rng;
			dtq_pkg::MODE_OUTSIDE:  cond = rng_dir && !in_rng;
			default:                cond = 1'b0;
		endcase
	end

	wire run      = state == dtq_pkg::ST_ARMED && armed && enabled;
	wire trig_now = run && cond;
	// Run ends: begin trace on a full FIFO after the trigger, end trace on the trigger.
	wire run_end  = run && (begin_tr ? (seen_trig && fifo_full_in)
	                                 : trig_now);
	wire brk_now  = run_end && ctrl[dtq_pkg::CTL_BRK];

	// ==========================================================
	// Control register and run state.
	wire [7:0] next_ctrl = wr_ctrl ? req_in.wdata
	                     : {ctrl[7], ctrl[6] & ~run_end, ctrl[5:0]};
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctrl  <= dtq_pkg::REG_RESET;
			state <= dtq_pkg::ST_IDLE;
		end else begin
			ctrl <= next_ctrl;
			unique case (state)
				dtq_pkg::ST_IDLE:
					if (next_ctrl[dtq_pkg::CTL_ARM]
					    && next_ctrl[dtq_pkg::CTL_EN]) begin
						state <= dtq_pkg::ST_ARMED;
					end
				dtq_pkg::ST_ARMED:
					if (run_end) begin
						state <= dtq_pkg::ST_DONE;
					end else if (!next_ctrl[dtq_pkg::CTL_ARM]
					             || !next_ctrl[dtq_pkg::CTL_EN]) begin
						state <= dtq_pkg::ST_IDLE;
					end
				dtq_pkg::ST_DONE:
					state <= dtq_pkg::ST_IDLE;
				default:
					state <= dtq_pkg::ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Trigger and comparator registers.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			trig_sel <= dtq_pkg::REG_RESET;
			cmp_a    <= {dtq_pkg::REG_RESET, dtq_pkg::REG_RESET};
			cmp_b    <= {dtq_pkg::REG_RESET, dtq_pkg::REG_RESET};
		end else if (!armed) begin
			if (wr_trig) begin
				trig_sel <= req_in.wdata & dtq_pkg::TRG_WMASK;
			end
			if (wr_cah) cmp_a[15:8] <= req_in.wdata;
			if (wr_cal) cmp_a[7:0]  <= req_in.wdata;
			if (wr_cbh) cmp_b[15:8] <= req_in.wdata;
			if (wr_cbl) cmp_b[7:0]  <= req_in.wdata;
		end
	end

	// ==========================================================
	// Run tracking: sequence, pending tags, match flags.
	wire start = state == dtq_pkg::ST_IDLE && next_ctrl[dtq_pkg::CTL_ARM]
	          && next_ctrl[dtq_pkg::CTL_EN];
	always_ff @(posedge clk_in) begin
		if (reset_in || start) begin
			seen_a    <= 1'b0;
			seen_trig <= 1'b0;
			pend_a    <= 1'b0;
			pend_b    <= 1'b0;
			flag_a    <= 1'b0;
			flag_b    <= 1'b0;
		end else if (run) begin
			seen_a    <= seen_a || ev_a;
			seen_trig <= seen_trig || trig_now;
			pend_a    <= (pend_a || match_a) && !tag_a;
			pend_b    <= (pend_b || match_b) && !tag_b;
			flag_a    <= flag_a || ev_a;
			flag_b    <= flag_b || ev_b;
		end
	end

	// ==========================================================
	// Interrupt status: set wins over write-one-to-clear.
	wire [IRQ_W_L-1:0] irq_set = {run_end, trig_now};
	wire [IRQ_W_L-1:0] next_irq_st = (irq_st
	                 & ~(wr_ist ? req_in.wdata[IRQ_W_L-1:0] : '0)) | irq_set;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			irq_st  <= '0;
			irq_msk <= '0;
		end else begin
			irq_st <= next_irq_st;
			if (wr_imsk) irq_msk <= req_in.wdata[IRQ_W_L-1:0];
		end
	end

	// ==========================================================
	// Read data and outputs.
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = dtq_pkg::BYTE_ZERO;
		if (req_in.rd) begin
			unique case (req_in.addr)
				dtq_pkg::ADDR_CTRL:   next_rdata = ctrl;
				dtq_pkg::ADDR_TRIG:   next_rdata = trig_sel;
				dtq_pkg::ADDR_CMPAH:  next_rdata = cmp_a[15:8];
				dtq_pkg::ADDR_CMPAL:  next_rdata = cmp_a[7:0];
				dtq_pkg::ADDR_CMPBH:  next_rdata = cmp_b[15:8];
				dtq_pkg::ADDR_CMPBL:  next_rdata = cmp_b[7:0];
				dtq_pkg::ADDR_STATUS: next_rdata = {flag_a, flag_b,
				                       armed & enabled, 5'b0_0000};
				dtq_pkg::ADDR_IRQST:  next_rdata = {6'h00, irq_st};
				dtq_pkg::ADDR_IRQMSK: next_rdata = {6'h00, irq_msk};
				default:              next_rdata = dtq_pkg::BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_out        <= dtq_pkg::BYTE_ZERO;
			trig_out         <= 1'b0;
			store_out        <= 1'b0;
			begin_trace_out  <= 1'b0;
			high_byte_en_out <= 1'b0;
			run_clear_out    <= 1'b0;
			break_out        <= 1'b0;
			break_tag_out    <= 1'b0;
			irq_out          <= 1'b0;
		end else begin
			rdata_out        <= next_rdata;
			trig_out         <= trig_now;
			store_out        <= run && (!begin_tr || seen_trig
			                    || trig_now);
			begin_trace_out  <= begin_tr;
			high_byte_en_out <= !ev_only;
			run_clear_out    <= start;
			break_out        <= brk_now;
			break_tag_out    <= ctrl[dtq_pkg::CTL_TAG];
			irq_out          <= |(next_irq_st & irq_msk);
		end
	end

	// ==========================================================
	// Assertions.
	brk_needs_en_a: assert property (@(posedge clk_in)
		disable iff (reset_in)
		break_out |-> $past(ctrl[dtq_pkg::CTL_BRK]))
		else $error("Break raised without break enable.");
	end_brk_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(brk_now && !begin_tr) |=> trig_out && break_out)
		else $error("End trace break not with trigger.");
	trig_locked_a: assert property (@(posedge clk_in)
		disable iff (reset_in)
		(armed && wr_trig) |=> $stable(trig_sel))
		else $error("Trigger register changed while armed.");
	trig_zero_a: assert property (@(posedge clk_in) disable iff (reset_in)
		trig_sel[5:4] == 2'b00)
		else $error("Trigger bits five and four not zero.");
	dir_a_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(match_a && ctrl[dtq_pkg::CTL_RWAE])
		|-> bus_in.read == ctrl[dtq_pkg::CTL_RWA])
		else $error("Comparator A matched wrong direction.");
	dir_b_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(match_b && ctrl[dtq_pkg::CTL_RWBE])
		|-> bus_in.read == ctrl[dtq_pkg::CTL_RWB])
		else $error("Comparator B matched wrong direction.");
	run_end_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(run_end && !wr_ctrl) |=> !armed ##1 state == dtq_pkg::ST_IDLE)
		else $error("Arm bit not cleared at end of run.");
	ev_begin_a: assert property (@(posedge clk_in) disable iff (reset_in)
		ev_only |=> begin_trace_out && !high_byte_en_out)
		else $error("Event-only mode not a begin trace.");
	no_trig_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(mode > dtq_pkg::MODE_OUTSIDE) |=> !trig_out)
		else $error("Undefined mode produced a trigger.");

endmodule

/* dtq_pkg.sv */
// Package of constants and types for the debug trigger qualifier.
package dtq_pkg;

	// ==========================================================
	// Register map.
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_TRIG   = 4'h1;
	localparam logic [3:0] ADDR_CMPAH  = 4'h2;
	localparam logic [3:0] ADDR_CMPAL  = 4'h3;
	localparam logic [3:0] ADDR_CMPBH  = 4'h4;
	localparam logic [3:0] ADDR_CMPBL  = 4'h5;
	localparam logic [3:0] ADDR_STATUS = 4'h6;
	localparam logic [3:0] ADDR_IRQST  = 4'h7;
	localparam logic [3:0] ADDR_IRQMSK = 4'h8;

	// ==========================================================
	// Control register fields.
	localparam int CTL_EN   = 7;
	localparam int CTL_ARM  = 6;
	localparam int CTL_TAG  = 5;
	localparam int CTL_BRK  = 4;
	localparam int CTL_RWA  = 3;
	localparam int CTL_RWAE = 2;
	localparam int CTL_RWB  = 1;
	localparam int CTL_RWBE = 0;

	// ==========================================================
	// Trigger register fields.
	localparam int TRG_TYPE  = 7;
	localparam int TRG_BEGIN = 6;
	localparam logic [7:0] TRG_WMASK  = 8'hCF;
	localparam logic [7:0] REG_RESET  = 8'h00;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;

	// ==========================================================
	// Status and interrupt fields.
	localparam int ST_AF   = 7;
	localparam int ST_BF   = 6;
	localparam int ST_ARMED_STATUS_FLAG = 5;
	localparam int IRQ_TRIG = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_W    = 2;

	// ==========================================================
	// Trigger modes.
	typedef enum logic [3:0] {
		MODE_A_ONLY   = 4'h0,
		MODE_A_OR_B   = 4'h1,
		MODE_A_THEN_B = 4'h2,
		MODE_EV_B     = 4'h3,
		MODE_A_EV_B   = 4'h4,
		MODE_A_AND_B  = 4'h5,
		MODE_A_NOT_B  = 4'h6,
		MODE_INSIDE   = 4'h7,
		MODE_OUTSIDE  = 4'h8
	} dtq_mode_type;

	// Run states, Gray coded along idle, armed, done.
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ARMED = 2'b01,
		ST_DONE  = 2'b11
	} dtq_state_type;

	// ==========================================================
	// Bus cycle seen by the comparators.
	typedef struct packed {
		logic        valid;
		logic        read;
		logic [15:0] addr;
		logic [7:0]  data;
	} dtq_bus_type;

	// Register port request.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} dtq_req_type;

endpackage

/* dtq_cpu_model.sv */
// Behavioural model of the CPU bus and break input seen by the qualifier.
`timescale 1ns/100ps
module dtq_cpu_model (
	// Clock and break request from the qualifier.
	input  wire logic            clk_in,
	input  wire logic            break_in,
	// Watched bus and opcode execution.
	output dtq_pkg::dtq_bus_type bus_out,
	output logic                 op_exec_out,
	output logic [15:0]          op_addr_out
);
	int brk_count = 0;

	// ==========================================================
	// Idle lines carry the inverse of the last value.
	initial begin
		bus_out = '0;
		op_exec_out = 1'b0;
		op_addr_out = 16'hFFFF;
	end

	// Counts break pulses taken by the core.
	always @(posedge clk_in) begin
		if (break_in === 1'b1) begin
			brk_count++;
		end
	end

	// One bus cycle, held for exactly one clock.
	task automatic access(input logic [15:0] a, input logic r,
			input logic [7:0] d);
		@(posedge clk_in);
		bus_out <= '{valid: 1'b1, read: r, addr: a, data: d};
		@(posedge clk_in);
		bus_out <= '{valid: 1'b0, read: ~r, addr: ~a, data: ~d};
	endtask

	// One opcode execution at an address.
	task automatic execute(input logic [15:0] a);
		@(posedge clk_in);
		op_exec_out <= 1'b1;
		op_addr_out <= a;
		@(posedge clk_in);
		op_exec_out <= 1'b0;
		op_addr_out <= ~a;
	endtask
endmodule

/* test_debug_trigger_qualifier.sv */
// Self-checking testbench of the debug trigger qualifier.
`timescale 1ns/100ps
module test_debug_trigger_qualifier;
	logic                 clk_in = 1'b0;
	logic                 reset_in = 1'b1;
	logic                 fifo_full = 1'b0;
	dtq_pkg::dtq_req_type req = '0;
	dtq_pkg::dtq_bus_type bus;
	logic                 op_exec, trig, store, begin_tr, hbe, run_clr;
	logic                 brk, brk_tag, irq, sel, en, dir, r;
	logic [15:0]          op_addr, ca, cb;
	logic [7:0]           rdata, rv, ctl;
	int                   bad_count = 0, checks_done = 0, seed = 32'h897e;
	int                   trig_n = 0, cyc = 0, t_trig = 0, t_brk = 0, b0;
	int                   clr_n = 0;

	always #25 clk_in = ~clk_in;

	dtq_top dut_u (.clk_in(clk_in), .reset_in(reset_in), .req_in(req),
		.rdata_out(rdata), .bus_in(bus), .op_exec_in(op_exec),
		.op_addr_in(op_addr), .fifo_full_in(fifo_full), .trig_out(trig),
		.store_out(store), .begin_trace_out(begin_tr),
		.high_byte_en_out(hbe), .run_clear_out(run_clr), .break_out(brk),
		.break_tag_out(brk_tag), .irq_out(irq));
	dtq_cpu_model cpu_u (.clk_in(clk_in), .break_in(brk), .bus_out(bus),
		.op_exec_out(op_exec), .op_addr_out(op_addr));

	// ==========================================================
	// Pulse monitor.
	always @(posedge clk_in) begin
		cyc++;
		if (trig === 1'b1) begin
			trig_n++;
			t_trig = cyc;
		end
		if (brk === 1'b1) begin
			t_brk = cyc;
		end
		if (run_clr === 1'b1) begin
			clr_n++;
		end
	end

	// ==========================================================
	// Shared tasks.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_in);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_in);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_in);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		@(negedge clk_in);
		d = rdata;
	endtask

	// Arms one run, makes one bus cycle and counts the pulses.
	task automatic run(input logic [7:0] trg, input logic [7:0] c,
			input logic [15:0] a, input logic rw, input int et, input int eb);
		clr_n = 0;
		wr(dtq_pkg::ADDR_CTRL, 8'h00);
		wr(dtq_pkg::ADDR_TRIG, trg);
		wr(dtq_pkg::ADDR_CTRL, c);
		trig_n = 0;
		b0 = cpu_u.brk_count;
		cpu_u.access(a, rw, ~cb[7:0]);
		repeat (6) @(posedge clk_in);
		@(negedge clk_in);
		check(16'(trig_n), 16'(et));
		check(16'(cpu_u.brk_count - b0), 16'(eb));
		check(16'(clr_n), 16'h0001);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		rd(dtq_pkg::ADDR_TRIG, rv);
		check(rv, 8'h00);
		ca = {1'b0, 15'($random(seed))};
		cb = ca + 16'h0001 + 16'($random(seed) & 255);
		wr(dtq_pkg::ADDR_CMPAH, ca[15:8]);
		wr(dtq_pkg::ADDR_CMPAL, ca[7:0]);
		wr(dtq_pkg::ADDR_CMPBH, cb[15:8]);
		wr(dtq_pkg::ADDR_CMPBL, cb[7:0]);
		wr(dtq_pkg::ADDR_TRIG, 8'hFF);
		rd(dtq_pkg::ADDR_TRIG, rv);
		check(rv, 8'hCF);
		wr(dtq_pkg::ADDR_CTRL, 8'hC0);
		wr(dtq_pkg::ADDR_TRIG, 8'h00);
		rd(dtq_pkg::ADDR_TRIG, rv);
		check(rv, 8'hCF);
		$display("test register access done");
		run(8'h00, 8'hD0, ca, 1'b0, 1, 1);
		check(16'(t_trig), 16'(t_brk));
		rd(dtq_pkg::ADDR_CTRL, rv);
		check(rv, 8'h90);
		for (int m = 0; m < 16; m++) begin
			b0 = (m < 2 || m == 6 || m == 7) ? 1 : 0;
			run(8'(m), 8'hD0, ca, 1'b1, b0, b0);
		end
		run(8'h07, 8'hD0, cb, 1'b1, 1, 1);
		run(8'h07, 8'hD0, cb + 16'h0001, 1'b1, 0, 0);
		run(8'h08, 8'hD0, cb + 16'h0001, 1'b1, 1, 1);
		$display("test trigger modes done");
		for (int k = 0; k < 16; k++) begin
			{sel, en, dir, r} = 4'(k);
			ctl = sel ? {6'h30, dir, en} : {4'hC, dir, en, 2'b00};
			run({7'h00, sel}, ctl, sel ? cb : ca, r, (!en || dir == r),
				0);
		end
		$display("test direction qualifiers done");
		run(8'h40, 8'hD0, ca, 1'b0, 1, 0);
		check({begin_tr, store}, 2'b11);
		@(posedge clk_in);
		fifo_full <= 1'b1;
		repeat (4) @(posedge clk_in);
		fifo_full <= 1'b0;
		check(16'(cpu_u.brk_count - b0), 16'h0001);
		rd(dtq_pkg::ADDR_CTRL, rv);
		check(rv, 8'h90);
		check(store, 1'b0);
		run(8'h03, 8'hD0, ca, 1'b0, 0, 0);
		check({begin_tr, hbe}, 2'b10);
		$display("test begin trace done");
		run(8'h80, 8'hF0, ca, 1'b0, 0, 0);
		cpu_u.execute(ca);
		repeat (6) @(posedge clk_in);
		@(negedge clk_in);
		check(16'(trig_n), 16'h0001);
		check(16'(t_trig), 16'(t_brk));
		check(brk_tag, 1'b1);
		$display("test tag trigger done");
		wr(dtq_pkg::ADDR_IRQST, 8'hFF);
		wr(dtq_pkg::ADDR_IRQMSK, 8'h00);
		run(8'h00, 8'hD0, ca, 1'b0, 1, 1);
		rd(dtq_pkg::ADDR_IRQST, rv);
		check({rv, 7'h00, irq}, 16'h0300);
		wr(dtq_pkg::ADDR_IRQMSK, 8'h03);
		@(posedge clk_in);
		@(negedge clk_in);
		check(irq, 1'b1);
		wr(dtq_pkg::ADDR_IRQMSK, 8'h00);
		wr(dtq_pkg::ADDR_IRQST, 8'h03);
		rd(dtq_pkg::ADDR_IRQST, rv);
		check({rv, 7'h00, irq}, 16'h0000);
		rd(4'hF, rv);
		check(rv, 8'h00);
		$display("test interrupt done");
		results();
	end
endmodule
